/* rtl/tad_alarm_core.sv */
/*
  Per-port receive alarm detection and transmit alarm control, with an
  Avalon-MM register slave.
  Assumes line bit and bit toggle arrive from pins; framer strobes share
  core_clk; long times are shortened through parameters in simulation.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tad_consts.svh"
module tad_alarm_core
  import tad_pkg::*;
#(
  parameter int unsigned PORT_NUM     = 1,
  parameter int unsigned BLUE_WIN_CYC = `TAD_BLUE_WIN_US * `TAD_CLK_MHZ,
  parameter int unsigned INTEG_CYC    = `TAD_INTEG_MS * 1000 * `TAD_CLK_MHZ,
  parameter int unsigned MF_WAIT_CYC  = `TAD_MF_WAIT_MS * 1000 * `TAD_CLK_MHZ
) (
  input  wire logic        core_clk,        // system clock
  input  wire logic        rst_n,           // sync reset
  input  wire logic [13:0] avs_address,     // byte address
  input  wire logic        avs_read,        // read request
  input  wire logic        avs_write,       // write request
  input  wire logic [31:0] avs_writedata,   // write data
  output logic      [31:0] avs_readdata,    // read data
  output logic             avs_waitrequest, // stall
  input  wire logic        rxLineBit,       // recovered line bit pin
  input  wire logic        rxBitToggle,     // toggles per line bit
  input  wire logic        rxFrameLoss,     // framer out of sync
  input  wire logic        rxFasSync,       // E1 FAS sync found
  input  wire logic        rxMfSync,        // E1 CRC-4 multiframe sync
  input  wire logic        chanBit2Stb,     // bit 2 of a channel
  input  wire logic        chanBit2,        // its value
  input  wire logic        fBit12Stb,       // twelfth F-bit present
  input  wire logic        fBit12,          // its value
  input  wire tad_fdl_t    fdlWord,         // data-link 16-bit word
  output logic             txForceAllOnes,  // send all ones
  output logic             txYellowSend,    // send yellow
  output logic             txYellowJ1,      // J1 form of yellow
  output logic             txYellowCi       // yellow-CI form
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // registers and bus slave
  logic [7:0]     rxCtl_q, txCtl1_q, txCtl2_q, txCtl4_q, boc_q, mode_q;
  logic [1:0]     latch_q;
  tad_rt_status_t rt_q;
  logic           blueCiSet, yelCiSet;
  logic [11:0]    idx;
  logic           acc, wr;
  assign idx = avs_address[13:2];
  assign acc = (avs_read | avs_write) & avs_waitrequest;
  assign wr  = avs_write & ~avs_waitrequest;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = a == (off + 12'((PORT_NUM - 1) * `TAD_PORT_STRIDE));
  endfunction

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~acc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc) begin
      avs_readdata <= 32'h0000_0000;
      if (hit(idx, `TAD_IDX_RXCTL2)) avs_readdata[7:0] <= rxCtl_q;
      if (hit(idx, `TAD_IDX_TXCTL1)) avs_readdata[7:0] <= txCtl1_q;
      if (hit(idx, `TAD_IDX_TXCTL2)) avs_readdata[7:0] <= txCtl2_q;
      if (hit(idx, `TAD_IDX_TXCTL4)) avs_readdata[7:0] <= txCtl4_q;
      if (hit(idx, `TAD_IDX_BOC))    avs_readdata[7:0] <= boc_q;
      if (hit(idx, `TAD_IDX_MODE))   avs_readdata[7:0] <= mode_q;
      if (hit(idx, `TAD_IDX_RTS))    avs_readdata[3:0] <= rt_q;
      if (hit(idx, `TAD_IDX_LATCH))  avs_readdata[1:0] <= latch_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxCtl_q  <= `TAD_CTL_RST;
      txCtl1_q <= `TAD_CTL_RST;
      txCtl2_q <= `TAD_CTL_RST;
      txCtl4_q <= `TAD_CTL_RST;
      boc_q    <= `TAD_CTL_RST;
      mode_q   <= `TAD_CTL_RST;
    end else if (wr) begin
      if (hit(idx, `TAD_IDX_RXCTL2)) rxCtl_q  <= avs_writedata[7:0];
      if (hit(idx, `TAD_IDX_TXCTL1)) txCtl1_q <= avs_writedata[7:0];
      if (hit(idx, `TAD_IDX_TXCTL2)) txCtl2_q <= avs_writedata[7:0];
      if (hit(idx, `TAD_IDX_TXCTL4)) txCtl4_q <= avs_writedata[7:0];
      if (hit(idx, `TAD_IDX_BOC))    boc_q    <= avs_writedata[7:0];
      if (hit(idx, `TAD_IDX_MODE))   mode_q   <= avs_writedata[7:0];
    end
  end

  // write-one-to-clear, a new event wins over the clear
  logic [1:0] latchClr;
  assign latchClr = (wr && hit(idx, `TAD_IDX_LATCH)) ? avs_writedata[1:0] : 2'h0;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latch_q <= 2'h0;
    end else begin
      latch_q <= (latch_q & ~latchClr) | {yelCiSet, blueCiSet};
    end
  end

  // ==========================================================
  // line bit synchroniser
  logic bitS1_q, bitS2_q, tglS1_q, tglS2_q, tglS3_q;
  logic bitStb, lineBit, zeroStb;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {bitS1_q, bitS2_q, tglS1_q, tglS2_q, tglS3_q} <= 5'h00;
    end else begin
      bitS1_q <= rxLineBit;
      bitS2_q <= bitS1_q;
      tglS1_q <= rxBitToggle;
      tglS2_q <= tglS1_q;
      tglS3_q <= tglS2_q;
    end
  end
  assign bitStb  = tglS2_q ^ tglS3_q;
  assign lineBit = bitS2_q;
  assign zeroStb = bitStb & ~lineBit;

  // ==========================================================
  // blue alarm over fixed windows
  logic [31:0] winCnt_q;
  logic [2:0]  zeroCnt_q, zeroNext;
  logic        blue_q;
  assign zeroNext = (zeroStb && zeroCnt_q != 3'h5) ? zeroCnt_q + 3'h1 : zeroCnt_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      winCnt_q  <= 32'h0000_0000;
      zeroCnt_q <= 3'h0;
      blue_q    <= 1'b0;
    end else if (winCnt_q == BLUE_WIN_CYC - 1) begin
      winCnt_q  <= 32'h0000_0000;
      zeroCnt_q <= 3'h0;
      blue_q    <= zeroNext <= `TAD_BLUE_MAX_ZEROS;
    end else begin
      winCnt_q  <= winCnt_q + 32'h1;
      zeroCnt_q <= zeroNext;
    end
  end
  blue_window_a: assert property ($changed(blue_q) |->
    $past(winCnt_q) == BLUE_WIN_CYC - 1) else $error("blue changed mid-window");

  // ==========================================================
  // carrier loss
  logic [7:0] zeroRun_q;
  logic [6:0] posCnt_q;
  logic [3:0] onesCnt_q;
  logic       losWin_q, los_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      zeroRun_q <= 8'h00;
    end else if (bitStb) begin
      zeroRun_q <= lineBit ? 8'h00 :
                   (zeroRun_q == `TAD_LOS_ZEROS) ? zeroRun_q : zeroRun_q + 8'h01;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      los_q     <= 1'b0;
      losWin_q  <= 1'b0;
      posCnt_q  <= 7'h00;
      onesCnt_q <= 4'h0;
    end else if (bitStb) begin
      if (!lineBit && zeroRun_q == `TAD_LOS_ZEROS - 8'h01) begin
        los_q    <= 1'b1;
        losWin_q <= 1'b0;
      end else if (los_q && !losWin_q && lineBit) begin
        losWin_q  <= 1'b1;
        posCnt_q  <= 7'h01;
        onesCnt_q <= 4'h1;
      end else if (los_q && losWin_q) begin
        posCnt_q  <= posCnt_q + 7'h01;
        onesCnt_q <= onesCnt_q + {3'h0, lineBit};
        if (lineBit && onesCnt_q == `TAD_LOS_ONES - 4'h1) begin
          los_q    <= 1'b0;
          losWin_q <= 1'b0;
        end else if (posCnt_q == `TAD_LOS_WIN - 7'h01) begin
          losWin_q <= 1'b0;
        end
      end
    end
  end
  los_set_a: assert property ($rose(los_q) |->
    $past(zeroRun_q) == 8'd191) else $error("carrier loss not after 192 zeros");
  los_clear_a: assert property ($fell(los_q) |->
    $past(onesCnt_q) == 4'd13 && $past(posCnt_q) < 7'd112) else $error("early los clear");

  // ==========================================================
  // yellow alarm detectors
  logic [7:0]  ch2Cnt_q;
  logic [8:0]  ch2Zero_q, ch2ZeroNext;
  logic        d4Yel_q, fbPrev_q, fbYel_q, esfRaw_q, esfRep_q;
  logic [15:0] esfHist_q, histNext;
  logic [31:0] integCnt_q;
  logic        patMatch;
  assign ch2ZeroNext = ch2Zero_q + {8'h00, ~chanBit2};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ch2Cnt_q  <= 8'h00;
      ch2Zero_q <= 9'h000;
      d4Yel_q   <= 1'b0;
    end else if (chanBit2Stb) begin
      ch2Cnt_q <= ch2Cnt_q + 8'h01;
      if (ch2Cnt_q == 8'hFF) begin
        d4Yel_q   <= ch2ZeroNext >= `TAD_D4_THRESH;
        ch2Zero_q <= 9'h000;
      end else begin
        ch2Zero_q <= ch2ZeroNext;
      end
    end
  end
  d4_window_a: assert property ($changed(d4Yel_q) |->
    $past(ch2Cnt_q) == 8'hFF && $past(chanBit2Stb)) else $error("d4 yellow off window");

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fbPrev_q <= 1'b0;
      fbYel_q  <= 1'b0;
    end else if (fBit12Stb) begin
      fbPrev_q <= fBit12;
      if (fBit12 && fbPrev_q) fbYel_q <= 1'b1;
      if (!fBit12 && !fbPrev_q) fbYel_q <= 1'b0;
    end
  end

  function automatic logic [4:0] popCount(input logic [15:0] v);
    popCount = 5'h00;
    for (int i = 0; i < 16; i++) popCount = popCount + {4'h0, v[i]};
  endfunction

  assign patMatch = fdlWord.word ==
    (rxCtl_q[`TAD_B_RX_J1] ? `TAD_PAT_J1 : `TAD_PAT_T1);
  assign histNext = {esfHist_q[14:0], patMatch};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      esfHist_q <= 16'h0000;
      esfRaw_q  <= 1'b0;
    end else if (fdlWord.stb) begin
      esfHist_q <= histNext;
      if (histNext == 16'hFFFF) esfRaw_q <= 1'b1;
      else if (popCount(histNext) <= `TAD_ESF_CLR_MAX) esfRaw_q <= 1'b0;
    end
  end
  esf_set_a: assert property ($rose(esfRaw_q) |->
    $past(esfHist_q[14:0]) == 15'h7FFF && $past(patMatch)) else $error("esf yellow early");

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      integCnt_q <= 32'h0000_0000;
      esfRep_q   <= 1'b0;
    end else if (!esfRaw_q) begin
      integCnt_q <= 32'h0000_0000;
      esfRep_q   <= 1'b0;
    end else if (!rxCtl_q[`TAD_B_INTEG] || integCnt_q == INTEG_CYC) begin
      esfRep_q <= 1'b1;
    end else begin
      integCnt_q <= integCnt_q + 32'h1;
    end
  end

  // ==========================================================
  // real-time status
  logic yelSel;
  assign yelSel = mode_q[`TAD_B_ESF] ? esfRep_q :
                  rxCtl_q[`TAD_B_D4_F12] ? fbYel_q : d4Yel_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rt_q <= '0;
    end else begin
      rt_q <= '{yellowAlarm: yelSel, blueAlarm: blue_q,
                carrierLoss: los_q, frameLoss: rxFrameLoss};
    end
  end

  // ==========================================================
  // blue-CI signature tracker
  logic [12:0] gap_q, gapNext, sigExp;
  logic [1:0]  stage_q;
  always_comb begin
    unique case (stage_q)
      2'd1:    sigExp = `TAD_SIG_Z1 - `TAD_SIG_Z0;
      2'd2:    sigExp = `TAD_SIG_Z2 - `TAD_SIG_Z1;
      2'd3:    sigExp = `TAD_SIG_LEN - `TAD_SIG_Z2 + `TAD_SIG_Z0;
      default: sigExp = 13'h0000;
    endcase
  end
  assign gapNext = (gap_q == 13'h1FFF) ? gap_q : gap_q + 13'h0001;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_q     <= 13'h0000;
      stage_q   <= 2'd0;
      blueCiSet <= 1'b0;
    end else begin
      blueCiSet <= 1'b0;
      if (zeroStb) begin
        gap_q <= 13'h0000;
        if (stage_q != 2'd0 && gapNext == sigExp) begin
          stage_q <= (stage_q == 2'd3) ? 2'd1 : stage_q + 2'd1;
          blueCiSet <= (stage_q == 2'd3) && blue_q;
        end else begin
          stage_q <= 2'd1;
        end
      end else if (bitStb) begin
        gap_q <= gapNext;
      end
    end
  end
  blue_ci_latch_a: assert property (blueCiSet |=>
    latch_q[`TAD_B_BLUE_CI]) else $error("blue-CI event lost");
  blue_ci_cause_a: assert property ($rose(latch_q[`TAD_B_BLUE_CI]) |->
    $past(blue_q, 2)) else $error("blue-CI without blue alarm");

  // ==========================================================
  // yellow-CI code detector
  logic [4:0] ciRun_q, ciNeed;
  always_comb begin
    unique case (boc_q[1:0])
      2'd0: ciNeed = 5'd1;
      2'd1: ciNeed = 5'd4;
      2'd2: ciNeed = 5'd8;
      2'd3: ciNeed = 5'd16;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ciRun_q  <= 5'h00;
      yelCiSet <= 1'b0;
    end else begin
      yelCiSet <= 1'b0;
      if (fdlWord.stb) begin
        if (fdlWord.word != `TAD_PAT_CI) begin
          ciRun_q <= 5'h00;
        end else if (ciRun_q != ciNeed) begin
          ciRun_q  <= ciRun_q + 5'h01;
          yelCiSet <= (ciRun_q + 5'h01 == ciNeed) && rt_q.yellowAlarm;
        end
      end
    end
  end
  yel_ci_cause_a: assert property ($rose(latch_q[`TAD_B_YEL_CI]) |->
    $past(rt_q.yellowAlarm, 2)) else $error("yellow-CI without yellow");

  // ==========================================================
  // transmit alarm control
  logic [31:0] mfCnt_q;
  logic        e1Cause;
  assign e1Cause = rxFrameLoss | blue_q | los_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mfCnt_q <= 32'h0000_0000;
    end else if (!(mode_q[`TAD_B_E1] && mode_q[`TAD_B_CRC4] && rxFasSync && !rxMfSync)) begin
      mfCnt_q <= 32'h0000_0000;
    end else if (mfCnt_q != MF_WAIT_CYC) begin
      mfCnt_q <= mfCnt_q + 32'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txForceAllOnes <= 1'b0;
      txYellowSend   <= 1'b0;
      txYellowJ1     <= 1'b0;
      txYellowCi     <= 1'b0;
    end else begin
      txForceAllOnes <= mode_q[`TAD_B_E1] & txCtl2_q[`TAD_B_AUTO_BLUE] & e1Cause;
      txYellowSend   <= txCtl1_q[`TAD_B_TX_YEL] |
        (mode_q[`TAD_B_E1] & txCtl2_q[`TAD_B_AUTO_YEL] &
         (e1Cause | (mfCnt_q == MF_WAIT_CYC)));
      txYellowJ1     <= txCtl2_q[`TAD_B_TX_J1];
      txYellowCi     <= mode_q[`TAD_B_ESF] & txCtl4_q[`TAD_B_TX_CI];
    end
  end
  tx_ais_a: assert property (mode_q[`TAD_B_E1] && txCtl2_q[`TAD_B_AUTO_BLUE] && e1Cause
    |=> txForceAllOnes) else $error("auto all-ones missing");
  tx_yel_a: assert property (txCtl1_q[`TAD_B_TX_YEL] |=> txYellowSend)
    else $error("yellow not sent");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("slow bus answer");
endmodule // tad_alarm_core
`default_nettype wire

/* rtl/tad_consts.svh */
/*
  Constants of the T1/E1 alarm block: register indices, field positions,
  reset values, thresholds and times.
  Assumes inclusion by bare name from the design files.
*/
`ifndef TAD_CONSTS_SVH
`define TAD_CONSTS_SVH
// ==========================================================
// register indices (byte address = 4 * index)
`define TAD_PORT_STRIDE 12'h200
`define TAD_IDX_RXCTL2  12'h014
`define TAD_IDX_TXCTL1  12'h181
`define TAD_IDX_TXCTL2  12'h182
`define TAD_IDX_TXCTL4  12'h186
`define TAD_IDX_BOC     12'h188
`define TAD_IDX_MODE    12'h189
`define TAD_IDX_RTS     12'h0B0
`define TAD_IDX_LATCH   12'h097
// ==========================================================
// field positions
`define TAD_B_D4_F12     0
`define TAD_B_INTEG      1
`define TAD_B_RX_J1      2
`define TAD_B_TX_YEL     0
`define TAD_B_TX_J1      0
`define TAD_B_AUTO_YEL   1
`define TAD_B_AUTO_BLUE  2
`define TAD_B_TX_CI      0
`define TAD_B_E1         0
`define TAD_B_ESF        1
`define TAD_B_CRC4       2
`define TAD_B_BLUE_CI    0
`define TAD_B_YEL_CI     1
`define TAD_CTL_RST      8'h00
// ==========================================================
// thresholds and patterns
`define TAD_BLUE_MAX_ZEROS 3'h4
`define TAD_LOS_ZEROS      8'hC0
`define TAD_LOS_ONES       4'hE
`define TAD_LOS_WIN        7'h70
`define TAD_D4_THRESH      9'h0FE
`define TAD_ESF_CLR_MAX    5'h0E
`define TAD_PAT_T1         16'h00FF
`define TAD_PAT_J1         16'hFFFF
`define TAD_PAT_CI         16'h3EFF
`define TAD_SIG_Z0         13'h0C10
`define TAD_SIG_Z1         13'h0D92
`define TAD_SIG_Z2         13'h169E
`define TAD_SIG_LEN        13'h1820
// ==========================================================
// times
`define TAD_CLK_MHZ        200
`define TAD_BLUE_WIN_US    3000
`define TAD_INTEG_MS       200
`define TAD_MF_WAIT_MS     128
`endif

/* rtl/tad_pkg.sv */
/*
  Types of the T1/E1 alarm block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package tad_pkg;
  // real-time receive alarm view
  typedef struct packed {
    logic yellowAlarm;
    logic blueAlarm;
    logic carrierLoss;
    logic frameLoss;
  } tad_rt_status_t;
  // data-link pattern strobe with its 16-bit word
  typedef struct packed {
    logic        stb;
    logic [15:0] word;
  } tad_fdl_t;
endpackage
`default_nettype wire

/* verification/tad_line_partner.sv */
/*
  Far-end line terminal model: line bits with their toggle, data-link words,
  channel bit-2 and twelfth F-bit strobes.
  Assumes the core_clk of the alarm core; tasks are called by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tad_line_partner
  import tad_pkg::*;
(
  input  wire logic     core_clk, // clock
  output var  logic     lineBit,  // line bit
  output var  logic     bitTgl,   // bit toggle
  output var  tad_fdl_t fdl,      // data-link word
  output var  logic     chStb,    // bit-2 strobe
  output var  logic     fStb,     // F-bit strobe
  output var  logic     strbVal   // strobe value
);
  initial begin
    lineBit = 1'b1;
    bitTgl  = 1'b0;
    fdl     = '0;
    chStb   = 1'b0;
    fStb    = 1'b0;
    strbVal = 1'b0;
  end
  // bit stands three clocks either side of its toggle
  task automatic send_bit(input logic b);
    @(posedge core_clk);
    lineBit <= b;
    repeat (3) @(posedge core_clk);
    bitTgl <= ~bitTgl;
    repeat (2) @(posedge core_clk);
  endtask
  // word turns to its inverse once its strobe is gone
  task automatic send_fdl(input logic [15:0] w);
    @(posedge core_clk);
    fdl <= '{stb: 1'b1, word: w};
    @(posedge core_clk);
    fdl <= '{stb: 1'b0, word: ~w};
  endtask
  task automatic send_strb(input logic f12, input logic b);
    @(posedge core_clk);
    chStb   <= ~f12;
    fStb    <= f12;
    strbVal <= b;
    @(posedge core_clk);
    chStb   <= 1'b0;
    fStb    <= 1'b0;
    strbVal <= ~b;
  endtask
endmodule // tad_line_partner
`default_nettype wire

/* verification/t1_e1_alarm_detect_generate_test.sv */
/*
  Self-checking bench of the alarm core with a far-end line model.
  Assumes tad_alarm_core, tad_line_partner and tad_pkg; short time params.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tad_consts.svh"
module t1_e1_alarm_detect_generate_test;
  import tad_pkg::*;
  localparam int PORT = 2;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rxFrameLoss = 1'b0;
  logic        rxFasSync = 1'b0;
  logic        rxMfSync = 1'b0;
  logic        lineBit, bitTgl, chStb, fStb, strbVal;
  tad_fdl_t    fdl;
  logic        txForceAllOnes, txYellowSend, txYellowJ1, txYellowCi;
  int          err_total = 0;
  int          samples_checked = 0;
  int          zeroRun = 0;
  int          oneCnt = 0;
  int          winPos = 0;
  logic        losExp = 1'b0;
  logic        yelExp = 1'b0;
  logic [31:0] rng = 32'h0000_7D26;
  logic [31:0] rd;
  logic [7:0]  ctlM [int];
  bit          hitQ [$];
  always #2.5 core_clk = ~core_clk;
  tad_alarm_core #(.PORT_NUM(PORT), .BLUE_WIN_CYC(60), .INTEG_CYC(100), .MF_WAIT_CYC(100))
  tad_alarm_core_inst (
    .core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .rxLineBit(lineBit), .rxBitToggle(bitTgl),
    .rxFrameLoss, .rxFasSync, .rxMfSync, .chanBit2Stb(chStb), .chanBit2(strbVal),
    .fBit12Stb(fStb), .fBit12(strbVal), .fdlWord(fdl), .txForceAllOnes,
    .txYellowSend, .txYellowJ1, .txYellowCi
  );
  tad_line_partner tad_line_partner_inst (
    .core_clk, .lineBit, .bitTgl, .fdl, .chStb, .fStb, .strbVal
  );
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [13:0] adr(input int idx, input int port);
    return 14'((idx + (port - 1) * `TAD_PORT_STRIDE) * 4);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    for (int n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic wr(input int idx, input logic [7:0] d);
    ctlM[idx] = d;
    bus(1'b1, adr(idx, PORT), d);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rdchk(input int idx, input logic [7:0] e);
    bus(1'b0, adr(idx, PORT), 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic rts(input int b, input logic e);
    repeat (4) @(posedge core_clk);
    bus(1'b0, adr(`TAD_IDX_RTS, PORT), 8'h00);
    chk(32'(rd[b]), 32'(e));
  endtask
  // line model: zero run and ones window from the first one
  task automatic bits(input logic b, input int n);
    repeat (n) begin
      tad_line_partner_inst.send_bit(b);
      zeroRun = b ? 0 : zeroRun + 1;
      if (zeroRun == 192) losExp = 1'b1;
      if (losExp && (winPos > 0 || b)) begin
        winPos++;
        oneCnt += b;
        if (oneCnt == 14) losExp = 1'b0;
        if (winPos == 112 || !losExp) begin
          winPos = 0;
          oneCnt = 0;
        end
      end
    end
  endtask
  task automatic pat(input logic [9:0] m, input int n);
    for (int i = 0; i < n; i++) bits(m[i % 10], 1);
  endtask
  task automatic blue(input logic [9:0] m, input logic e);
    fork
      pat(m, 60);
      begin
        repeat (250) @(posedge core_clk);
        rts(2, e);
      end
    join
  endtask
  // data-link model: match history of the last 16 words
  task automatic fw(input logic [15:0] w, input logic [15:0] p);
    int c;
    c = 0;
    tad_line_partner_inst.send_fdl(w);
    hitQ.push_back(w == p);
    if (hitQ.size() > 16) void'(hitQ.pop_front());
    foreach (hitQ[i]) c += hitQ[i];
    if (c == 16) yelExp = 1'b1;
    else if (c <= 14) yelExp = 1'b0;
  endtask
  // ==========================================================
  // scenarios
  initial begin : main
    int regs[4] = '{`TAD_IDX_RXCTL2, `TAD_IDX_TXCTL1, `TAD_IDX_TXCTL2, `TAD_IDX_TXCTL4};
    logic [15:0] p;
    logic [31:0] r;
    int m;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk(regs[i], 8'h00);
    wr(`TAD_IDX_TXCTL1, 8'h01);
    bus(1'b0, adr(`TAD_IDX_TXCTL1, 1), 8'h00);
    chk(rd, 32'h0);
    rdchk(`TAD_IDX_TXCTL1, ctlM[`TAD_IDX_TXCTL1]);
    chk(txYellowSend, 1'b1);
    wr(`TAD_IDX_TXCTL2, 8'h01);
    chk(txYellowJ1, 1'b1);
    wr(`TAD_IDX_TXCTL4, 8'h01);
    chk(txYellowCi, 1'b0);
    wr(`TAD_IDX_MODE, 8'h02);
    chk(txYellowCi, 1'b1);
    for (int i = 0; i < 4; i++) wr(regs[i], 8'h00);
    wr(`TAD_IDX_MODE, 8'h00);
    bits(1'b0, 191);
    rts(1, losExp);
    bits(1'b0, 1);
    rts(1, losExp);
    bits(1'b1, 13);
    rts(1, losExp);
    bits(1'b1, 1);
    rts(1, losExp);
    blue(10'h3FF, 1'b1);
    blue(10'h2AA, 1'b0);
    blue(10'h2B5, 1'b1);
    wr(`TAD_IDX_MODE, 8'h01);
    wr(`TAD_IDX_TXCTL2, 8'h04);
    chk(txForceAllOnes, 1'b1);
    wr(`TAD_IDX_TXCTL2, 8'h02);
    chk(txForceAllOnes, 1'b0);
    chk(txYellowSend, 1'b1);
    fork
      pat(10'h2AA, 120);
      begin
        repeat (250) @(posedge core_clk);
        chk(txYellowSend, 1'b0);
        rxFrameLoss <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(txYellowSend, 1'b1);
        rxFrameLoss <= 1'b0;
        wr(`TAD_IDX_MODE, 8'h05);
        rxFasSync <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk(txYellowSend, 1'b0);
        repeat (100) @(posedge core_clk);
        chk(txYellowSend, 1'b1);
        rxMfSync <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(txYellowSend, 1'b0);
      end
    join
    wr(`TAD_IDX_TXCTL2, 8'h00);
    wr(`TAD_IDX_MODE, 8'h02);
    for (int j = 0; j < 2; j++) begin
      p = j ? `TAD_PAT_J1 : `TAD_PAT_T1;
      wr(`TAD_IDX_RXCTL2, j ? 8'h04 : 8'h00);
      for (int k = 0; k < 18; k++) begin
        r = xs();
        fw(k < 16 ? p : {2'b01, r[13:0]}, p);
        rts(3, yelExp);
      end
    end
    wr(`TAD_IDX_RXCTL2, 8'h06);
    for (int k = 0; k < 16; k++) fw(`TAD_PAT_J1, `TAD_PAT_J1);
    rts(3, 1'b0);
    repeat (100) @(posedge core_clk);
    rts(3, yelExp);
    fw(`TAD_PAT_CI, `TAD_PAT_J1);
    rdchk(`TAD_IDX_LATCH, 8'h02);
    rts(3, yelExp);
    rdchk(`TAD_IDX_LATCH, 8'h02);
    wr(`TAD_IDX_LATCH, 8'h00);
    rdchk(`TAD_IDX_LATCH, 8'h02);
    wr(`TAD_IDX_LATCH, 8'h02);
    rdchk(`TAD_IDX_LATCH, 8'h00);
    wr(`TAD_IDX_BOC, 8'h01);
    fw(`TAD_PAT_J1, `TAD_PAT_J1);
    repeat (3) fw(`TAD_PAT_CI, `TAD_PAT_J1);
    rdchk(`TAD_IDX_LATCH, 8'h00);
    wr(`TAD_IDX_MODE, 8'h00);
    wr(`TAD_IDX_RXCTL2, 8'h00);
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 256; c++) tad_line_partner_inst.send_strb(1'b0, c < 2 + b);
      rts(3, (256 - (2 + b)) >= 254);
    end
    wr(`TAD_IDX_RXCTL2, 8'h01);
    for (int k = 0; k < 4; k++) begin
      tad_line_partner_inst.send_strb(1'b1, k < 2);
      rts(3, k == 1 || k == 2);
    end
    for (int i = 0; i < 9400; i++) begin
      m = i % 6176;
      bits(!(m == 3088 || m == 3474 || m == 5790), 1);
    end
    rdchk(`TAD_IDX_LATCH, 8'h01);
    print_verdict();
  end
  initial begin : watchdog
    repeat (100000) @(posedge core_clk);
    err_total++;
    print_verdict();
  end
endmodule // t1_e1_alarm_detect_generate_test
`default_nettype wire
